/* File: pkg/btf_pkg.sv */
package btf_pkg;
	// ***************************
	// opcode fields
	// ***************************
	localparam logic [3:0] BTF_TOGGLE_NIB = 4'h7;
	localparam logic [7:0] BTF_OVBR_BYTE = 8'he4;
	localparam logic [7:0] BTF_ZBR_BYTE = 8'he0;
	localparam int BTF_BIT_LSB = 9;
	localparam int BTF_ACC_POS = 8;
	localparam logic [3:0] BTF_ACCESS_BANK = 4'h0;
	localparam int BTF_PC_W = 21;
	localparam logic [BTF_PC_W-1:0] BTF_PC_STEP = 21'h000002;
	localparam logic [BTF_PC_W-1:0] BTF_PC_RESET = 21'h000000;

	// ***************************
	// quarter-cycle phases
	// ***************************
	typedef enum logic [3:0]
	{
		BTF_Q1 = 4'h1,
		BTF_Q2 = 4'h2,
		BTF_Q3 = 4'h4,
		BTF_Q4 = 4'h8
	} btf_phase_t;
endpackage : btf_pkg

/* File: hdl/btf_decode.sv */
`timescale 1ns/10ps
module btf_decode
	import btf_pkg::*;
(
	// instruction word
	input wire logic [15:0] instr,
	// decoded class
	output logic isToggle,
	output logic isOvBranch,
	output logic isZeroBranch
);
	assign isToggle = (instr[15:12] == BTF_TOGGLE_NIB);
	assign isOvBranch = (instr[15:8] == BTF_OVBR_BYTE);
	assign isZeroBranch = (instr[15:8] == BTF_ZBR_BYTE);
endmodule : btf_decode

/* File: hdl/btf_exec.sv */
`timescale 1ns/10ps
// Function
// - toggle opcode 0111, bit, access, address
// - invert selected bit only, flags untouched
// - access bit 0 access bank, else bank select
// - eight-bit register address, 0 to 255
// - overflow branch upper byte 1110 0100
// - overflow branch taken only when flag set
// - target is incremented pc plus twice offset
// - one word, one cycle, two when taken
// - q4 writes pc then nop cycle if taken
// - zero branch upper byte 1110 0000
// - zero branch taken only when flag set
module btf_exec
	import btf_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// instruction and status
	input wire logic [15:0] instr,
	input wire logic ovFlag,
	input wire logic zeroFlag,
	input wire logic [3:0] bank_select_register,
	// data memory
	output logic [11:0] memAddr,
	input wire logic [7:0] memRdata,
	output logic [7:0] memWdata,
	output logic memRd,
	output logic memWr,
	// program counter
	output logic [BTF_PC_W-1:0] pc,
	output logic flush,
	output logic [3:0] phase
);
	// ***************************
	// decode
	// ***************************
	logic isToggle;
	logic isOvBranch;
	logic isZeroBranch;
	btf_phase_t phase_r;
	logic [15:0] ir_r;
	logic ovS_r;
	logic zS_r;
	logic take_r;
	logic nop_r;
	logic [7:0] data_r;
	logic [BTF_PC_W-1:0] pc_r;
	logic [BTF_PC_W-1:0] target;

	btf_decode uDec
	(
		.instr(ir_r),
		.isToggle(isToggle),
		.isOvBranch(isOvBranch),
		.isZeroBranch(isZeroBranch)
	);

	// ***************************
	// phase sequencer
	// ***************************
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			phase_r <= BTF_Q1;
		else
			case (phase_r)
				BTF_Q1: phase_r <= BTF_Q2;
				BTF_Q2: phase_r <= BTF_Q3;
				BTF_Q3: phase_r <= BTF_Q4;
				BTF_Q4: phase_r <= BTF_Q1;
				default: phase_r <= BTF_Q1;
			endcase
	end

	// instruction latched in q1 of an execute cycle, not a nop cycle
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ir_r <= 16'h0000;
			ovS_r <= 1'b0;
			zS_r <= 1'b0;
		end
		else if (phase_r == BTF_Q1)
		begin
			ir_r <= nop_r ? 16'h0000 : instr;
			ovS_r <= ovFlag;
			zS_r <= zeroFlag;
		end
	end

	// ***************************
	// branch
	// ***************************
	// sign-extend then double; 21-bit wrap is the core's address space
	assign target = pc_r + BTF_PC_STEP
		+ {{(BTF_PC_W-9){ir_r[7]}}, ir_r[7:0], 1'b0};

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			take_r <= 1'b0;
		else if (phase_r == BTF_Q3)
			take_r <= (isOvBranch && ovS_r)
				|| (isZeroBranch && zS_r);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			pc_r <= BTF_PC_RESET;
		else if (phase_r == BTF_Q4)
			pc_r <= take_r ? target : pc_r + BTF_PC_STEP;
	end

	// second cycle of a taken branch is a forced nop
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			nop_r <= 1'b0;
		else if (phase_r == BTF_Q4)
			nop_r <= take_r;
	end

	// ***************************
	// bit toggle
	// ***************************
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			data_r <= 8'h00;
		else if (phase_r == BTF_Q2)
			data_r <= memRdata;
		else if (phase_r == BTF_Q3)
			data_r <= data_r ^ (8'h01 << ir_r[BTF_BIT_LSB+:3]);
	end

	always_comb
	begin
		memAddr = {ir_r[BTF_ACC_POS] ? bank_select_register
			: BTF_ACCESS_BANK, ir_r[7:0]};
		memRd = isToggle && (phase_r == BTF_Q2);
		memWr = isToggle && (phase_r == BTF_Q4);
	end

	assign memWdata = data_r;
	assign pc = pc_r;
	assign flush = nop_r;
	assign phase = phase_r;
endmodule : btf_exec

/* File: sim/btf_exec_props.sv */
`timescale 1ns/10ps
module btf_exec_props
	import btf_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic memRd,
	input wire logic memWr,
	input wire logic flush,
	input wire logic [20:0] pc,
	input wire logic [3:0] phase
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	rd_q2_a: assert property (memRd|->phase==BTF_Q2)
		else $error("rd");
	wr_q4_a: assert property (memWr|->phase==BTF_Q4)
		else $error("wr");
	rd_wr_a: assert property (memRd|->##2 memWr)
		else $error("rw");
	nop_len_a: assert property ($rose(flush)|->flush[*4] ##1 !flush)
		else $error("nop");
	nop_at_a: assert property ($rose(flush)|->$past(phase)==BTF_Q4)
		else $error("at");
	pc_hold_a: assert property (phase!=BTF_Q4|=>$stable(pc))
		else $error("pc");
	nop_quiet_a: assert property (flush|->!memRd&&!memWr)
		else $error("q");
	nop_step_a: assert property (flush && phase == BTF_Q4
		|=> pc == $past(pc) + 21'h2)
		else $error("st");
endmodule : btf_exec_props
bind btf_exec btf_exec_props u_props (.clk(clk), .nrst(nrst), .memRd(memRd),
	.memWr(memWr), .flush(flush), .pc(pc), .phase(phase));

/* File: sim/btf_mem.sv */
`timescale 1ns/10ps
module btf_mem
(
	input wire logic clk,
	input wire logic [11:0] a,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] wd,
	output logic [7:0] rdat
);
	logic [7:0] m [4096];
	initial for (int i = 0; i < 4096; i++) m[i] = 8'(i * 37);
	// unselected bus shows no stale byte
	assign rdat = rd ? m[a] : ~m[a];
	always @(posedge clk) if (wr) m[a] <= wd;
endmodule : btf_mem

/* File: sim/tb_bit_toggle_and_flag_branch_exec.sv */
`timescale 1ns/10ps
module tb_bit_toggle_and_flag_branch_exec;
	import btf_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, ov = 1'b0, zf = 1'b0, rd, wr, fl;
	logic [15:0] ins = 16'h0;
	logic [3:0] bs = 4'h0, ph;
	logic [11:0] ma;
	logic [7:0] rdat, wd, op;
	logic [20:0] pc, t;
	logic [31:0] s = 32'h994c3e70;
	int fails = 0, n_checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	btf_exec DUT (.clk(clk), .nrst(nrst), .instr(ins), .ovFlag(ov),
		.zeroFlag(zf), .bank_select_register(bs), .memAddr(ma), .memRdata(rdat),
		.memWdata(wd), .memRd(rd), .memWr(wr), .pc(pc), .flush(fl), .phase(ph));
	btf_mem mem (.clk(clk), .a(ma), .rd(rd), .wr(wr), .wd(wd), .rdat(rdat));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	task chk(input logic [31:0] c, input logic [31:0] e);
		n_checks++;
		if (c !== e)
		begin
			fails++;
			$display("unexpected %0t seen %h want %h", $time, c, e);
		end
	endtask : chk
	task finish_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	function automatic logic [20:0] pc_after(input logic [20:0] p,
		input logic [7:0] n, input logic tk);
		return p + 21'h2 + (tk ? {{12{n[7]}}, n, 1'b0} : 21'h0);
	endfunction : pc_after
	task run(input logic [15:0] w, input logic [5:0] f);
		logic tk;
		logic tg;
		logic [11:0] a;
		tg = w[15:12] == BTF_TOGGLE_NIB;
		tk = (w[15:8] == BTF_OVBR_BYTE && f[0])
			|| (w[15:8] == BTF_ZBR_BYTE && f[1]);
		a = {w[8] ? f[5:2] : BTF_ACCESS_BANK, w[7:0]};
		t = pc;
		ins = w;
		{bs, zf, ov} = f;
		@(negedge clk);
		{zf, ov} = ~f[1:0];
		chk(rd, tg);
		repeat (2) @(negedge clk);
		chk(wr, tg);
		if (tg) chk({ma, wd}, {a, mem.m[a] ^ (8'h1 << w[11:9])});
		@(negedge clk);
		chk(fl, tk);
		chk(pc, pc_after(t, w[7:0], tk));
		if (tk)
		begin
			t = pc;
			ins = 16'h7000;
			repeat (4) @(negedge clk);
			chk(pc, pc_after(t, 8'h00, 1'b0));
		end
	endtask : run
	always @(posedge clk)
		if (++cyc > 1000)
		begin
			fails++;
			finish_test;
		end
	initial
	begin
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		run(16'he480, 6'h03);
		run(16'he07f, 6'h02);
		run(16'he07f, 6'h01);
		run(16'he47f, 6'h02);
		run(16'h7fff, 6'h3c);
		run(16'h7eff, 6'h3c);
		repeat (60)
		begin
			s = xs(s);
			op = s[1] ? {4'he, s[0] ? 4'h4 : 4'h0}
				: {s[0] ? 4'h7 : s[15:12], s[11:8]};
			run({op, s[23:16]}, s[29:24]);
		end
		finish_test;
	end
endmodule : tb_bit_toggle_and_flag_branch_exec
